// ==== bench/air_bank_tb_top.sv ====
// Self-checking testbench for the auxiliary input result register bank.
`timescale 1ns/1ps
module air_bank_tb_top;

  // ==========================================================================
  // Signals and counters
  // ==========================================================================
  localparam int LIMIT = 5000;
  logic                                    clk       = 1'b0;
  logic                                    rst       = 1'b1;
  logic [air_pkg::AIR_ADDR_W-1:0]          address   = '0;
  logic                                    read      = 1'b0;
  logic                                    write     = 1'b0;
  logic [air_pkg::AIR_DATA_W-1:0]          writedata = '0;
  logic                                    waitrequest;
  logic [air_pkg::AIR_DATA_W-1:0]          readdata;
  logic [1:0]                              response;
  air_pkg::air_result_s [air_pkg::AIR_NCH-1:0] conv  = '0;
  logic [air_pkg::AIR_NCH-1:0]             lock_status;
  int                                      fails     = 0;
  int                                      samples_checked = 0;
  int                                      cycles    = 0;

  air_bank uut (
    .clk         (clk),
    .rst         (rst),
    .address     (address),
    .read        (read),
    .write       (write),
    .writedata   (writedata),
    .waitrequest (waitrequest),
    .readdata    (readdata),
    .response    (response),
    .result      (conv),
    .lock_status (lock_status)
  );

  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk = ~clk;
  end

  // Cuts a hang short; the ceiling is far above what the tests need.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fails++;
      $display("CHECK FAILED at %0t: run took too long", $time);
      print_verdict();
    end
  end

  // ==========================================================================
  // Compare tasks
  // ==========================================================================
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: readdata %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: response %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_lock(input logic [3:0] exp);
    samples_checked++;
    if (lock_status !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: lock_status %h expected %h", $time, lock_status, exp);
    end
  endtask

  // ==========================================================================
  // Bus and stimulus tasks
  // ==========================================================================
  // One Avalon access; waitrequest and the answer are taken at the rising
  // edge at which waitrequest is seen low, and only then is the request dropped.
  task automatic bus_op(input logic wr, input logic [13:0] idx, input logic [31:0] wd,
                        output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    read      <= ~wr;
    write     <= wr;
    address   <= {idx, 2'b00};
    writedata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    if (n >= 100) begin
      fails++;
      $display("CHECK FAILED at %0t: no bus answer", $time);
    end
    d = readdata;
    r = response;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [13:0] idx, input logic [7:0] exp, input logic [1:0] exp_r);
    logic [31:0] d;
    logic [1:0]  r;
    bus_op(1'b0, idx, 32'h00000000, d, r);
    chk_data(d, {24'h000000, exp});
    chk_resp(r, exp_r);
  endtask

  // A single-cycle conversion pulse on one input.
  task automatic convert(input int ch, input logic [7:0] h, input logic [7:0] l);
    @(posedge clk);
    conv[ch] <= '{1'b1, h, l};
    @(posedge clk);
    conv[ch].valid <= 1'b0;
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    chk_lock(4'h0);
    // Reset values of every byte; each high read is paired with its low read.
    for (int i = 0; i < 4; i++) begin
      rd_chk(air_pkg::AIR_IDX_HI[i], 8'h80, air_pkg::AIR_RESP_OKAY);
      rd_chk(air_pkg::AIR_IDX_LO[i], 8'h00, air_pkg::AIR_RESP_OKAY);
    end
    $display("test reset_values done");
    // High read freezes the low byte; a newer low byte shows only after the low read.
    for (int i = 0; i < 4; i++) begin
      convert(i, 8'hA0 + 8'(i), 8'h30 + 8'(i));
      rd_chk(air_pkg::AIR_IDX_HI[i], 8'hA0 + 8'(i), air_pkg::AIR_RESP_OKAY);
      chk_lock(4'(1 << i));
      convert(i, 8'hC0 + 8'(i), 8'h50 + 8'(i));
      convert(i, 8'hD0 + 8'(i), 8'h60 + 8'(i));
      rd_chk(air_pkg::AIR_IDX_HI[i], 8'hD0 + 8'(i), air_pkg::AIR_RESP_OKAY);
      rd_chk(air_pkg::AIR_IDX_LO[i], 8'h30 + 8'(i), air_pkg::AIR_RESP_OKAY);
      chk_lock(4'h0);
      rd_chk(air_pkg::AIR_IDX_LO[i], 8'h60 + 8'(i), air_pkg::AIR_RESP_OKAY);
    end
    $display("test read_lock done");
    // Without a lock the low byte follows each conversion.
    convert(1, 8'h11, 8'h22);
    rd_chk(air_pkg::AIR_IDX_LO[1], 8'h22, air_pkg::AIR_RESP_OKAY);
    chk_lock(4'h0);
    $display("test unlocked_low done");
    // Writes are answered but change nothing.
    bus_op(1'b1, air_pkg::AIR_IDX_HI[1], 32'hFFFFFFFF, d, r);
    chk_resp(r, air_pkg::AIR_RESP_OKAY);
    chk_data(d, 32'h00000000);
    bus_op(1'b1, air_pkg::AIR_IDX_LO[1], 32'h5A5A5A5A, d, r);
    chk_resp(r, air_pkg::AIR_RESP_OKAY);
    chk_data(d, 32'h00000000);
    chk_lock(4'h0);
    rd_chk(air_pkg::AIR_IDX_HI[1], 8'h11, air_pkg::AIR_RESP_OKAY);
    rd_chk(air_pkg::AIR_IDX_LO[1], 8'h22, air_pkg::AIR_RESP_OKAY);
    $display("test write_ignored done");
    // Indices just outside the bank answer with an error and no data.
    rd_chk(14'h0595, 8'h00, air_pkg::AIR_RESP_SLVERR);
    rd_chk(14'h059E, 8'h00, air_pkg::AIR_RESP_SLVERR);
    chk_lock(4'h0);
    $display("test unmapped done");
    // A reset in mid-run drops a held lock and restores the reset values.
    rd_chk(air_pkg::AIR_IDX_HI[3], 8'hD3, air_pkg::AIR_RESP_OKAY);
    chk_lock(4'h8);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk_lock(4'h0);
    rd_chk(air_pkg::AIR_IDX_HI[3], 8'h80, air_pkg::AIR_RESP_OKAY);
    rd_chk(air_pkg::AIR_IDX_LO[0], 8'h00, air_pkg::AIR_RESP_OKAY);
    $display("test mid_reset done");
    print_verdict();
  end

endmodule

// ==== include/air_pkg.sv ====
// Constants and types shared by the auxiliary input result register bank.
package air_pkg;

  // ==========================================================================
  // Bank shape and bus geometry
  // ==========================================================================
  localparam int AIR_NCH     = 4;
  localparam int AIR_ADDR_W  = 16;
  localparam int AIR_DATA_W  = 32;
  localparam int AIR_IDX_W   = 14;
  localparam int AIR_IDX_LSB = 2;

  // ==========================================================================
  // Register indices; the byte address is four times the index
  // ==========================================================================
  localparam logic [13:0] AIR_IDX_IN5_HI = 14'h0596;
  localparam logic [13:0] AIR_IDX_IN5_LO = 14'h0597;
  localparam logic [13:0] AIR_IDX_IN6_HI = 14'h0598;
  localparam logic [13:0] AIR_IDX_IN6_LO = 14'h0599;
  localparam logic [13:0] AIR_IDX_IN7_HI = 14'h059A;
  localparam logic [13:0] AIR_IDX_IN7_LO = 14'h059B;
  localparam logic [13:0] AIR_IDX_IN8_HI = 14'h059C;
  localparam logic [13:0] AIR_IDX_IN8_LO = 14'h059D;

  localparam logic [13:0] AIR_IDX_HI [AIR_NCH] = '{AIR_IDX_IN5_HI, AIR_IDX_IN6_HI, AIR_IDX_IN7_HI, AIR_IDX_IN8_HI};
  localparam logic [13:0] AIR_IDX_LO [AIR_NCH] = '{AIR_IDX_IN5_LO, AIR_IDX_IN6_LO, AIR_IDX_IN7_LO, AIR_IDX_IN8_LO};

  // ==========================================================================
  // Values after reset and bus answers
  // ==========================================================================
  localparam logic [7:0]  AIR_HI_RESET    = 8'h80;
  localparam logic [7:0]  AIR_LO_RESET    = 8'h00;
  localparam logic [31:0] AIR_RDATA_RESET = 32'h00000000;
  localparam logic [1:0]  AIR_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  AIR_RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Types
  // ==========================================================================
  // One finished conversion of one input, valid for a single cycle.
  typedef struct packed {
    logic       valid;
    logic [7:0] high;
    logic [7:0] low;
  } air_result_s;

  typedef enum logic [1:0] {
    AIR_IDLE = 2'b01,
    AIR_ACK  = 2'b10
  } air_bus_e;

endpackage

// ==== logic/air_bank.sv ====
// Avalon-MM slave holding the result bytes of auxiliary inputs five to eight.
//
// Notes on behaviour
// - High read freezes the matching low byte.
// - Freeze lasts until low byte also read.
// - Input 5 low byte at 0x0597, resets zero.
// - Input 6 at 0x0598/0x0599; high resets 0x80.
// - Input 7 at 0x059A/0x059B with lock.
// - Input 8 high at 0x059C locks low.
// - Input 5 high at 0x0596 locks low.
`timescale 1ns/1ps
module air_bank #(
  parameter int NCH = air_pkg::AIR_NCH
) (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic [air_pkg::AIR_ADDR_W-1:0] address,
  input  wire logic                           read,
  input  wire logic                           write,
  input  wire logic [air_pkg::AIR_DATA_W-1:0] writedata,
  output logic                                waitrequest,
  output logic [air_pkg::AIR_DATA_W-1:0]      readdata,
  output logic [1:0]                          response,
  input  wire air_pkg::air_result_s [NCH-1:0] result,
  output logic [NCH-1:0]                      lock_status
);

  // ==========================================================================
  // Address decode
  // ==========================================================================
  logic [air_pkg::AIR_IDX_W-1:0] idx;
  logic [NCH-1:0]                sel_hi;
  logic [NCH-1:0]                sel_lo;
  logic [NCH-1:0]                rd_hi;
  logic [NCH-1:0]                rd_lo;
  logic [NCH-1:0]                ch_locked;
  logic [7:0]                    ch_high [NCH];
  logic [7:0]                    ch_low  [NCH];
  logic                          take;
  logic                          mapped;
  air_pkg::air_bus_e             state;

  // The two low address bits pick a byte lane inside a word and are ignored.
  // Spacing the registers a word apart costs address space, but every access
  // stays a plain aligned word for the bus.
  assign idx = address[air_pkg::AIR_ADDR_W-1:air_pkg::AIR_IDX_LSB];

  // A request is taken only from the idle state, so a request that the master
  // still holds during the answer cycle is never counted twice.
  assign take = (state == air_pkg::AIR_IDLE) && (read || write);

  assign mapped = |{sel_hi, sel_lo};

  // The write data path is deliberately unused: every register is read-only.
  logic unused_wdata;
  assign unused_wdata = ^writedata;

  // ==========================================================================
  // Result channels
  // ==========================================================================
  // The lock lives inside each channel so that every input behaves alike.
  genvar c;
  generate
    for (c = 0; c < NCH; c = c + 1) begin : g_ch
      // Each channel owns one high index and the index right above it.
      assign sel_hi[c] = (idx == air_pkg::AIR_IDX_HI[c]);
      assign sel_lo[c] = (idx == air_pkg::AIR_IDX_LO[c]);

      // Side effects of a read only; writes never reach the channel.
      assign rd_hi[c] = take && read && sel_hi[c];
      assign rd_lo[c] = take && read && sel_lo[c];

      air_channel u_ch (
        .clk    (clk),
        .rst    (rst),
        .result (result[c]),
        .rd_hi  (rd_hi[c]),
        .rd_lo  (rd_lo[c]),
        .high   (ch_high[c]),
        .low    (ch_low[c]),
        .locked (ch_locked[c])
      );
    end
  endgenerate

  // The lock flags come straight from the channel flip-flops.
  assign lock_status = ch_locked;

  // ==========================================================================
  // Read multiplexer
  // ==========================================================================
  logic [air_pkg::AIR_DATA_W-1:0] next_readdata;
  logic [1:0]                     next_response;

  // Bytes sit in the low lane and the upper bits read as zero. Writes answer
  // with zero data; an unmapped index answers with a slave error.
  // A read of an unmapped index selects no channel, so it touches no lock.
  always_comb begin
    next_readdata = air_pkg::AIR_RDATA_RESET;
    next_response = air_pkg::AIR_RESP_SLVERR;
    for (int i = 0; i < NCH; i++) begin
      if (sel_hi[i]) begin
        next_response = air_pkg::AIR_RESP_OKAY;
        if (read) begin
          next_readdata[7:0] = ch_high[i];
        end
      end
      if (sel_lo[i]) begin
        next_response = air_pkg::AIR_RESP_OKAY;
        if (read) begin
          next_readdata[7:0] = ch_low[i];
        end
      end
    end
  end

  // ==========================================================================
  // Bus handshake
  // ==========================================================================
  // Two states: idle, and the single answer cycle with waitrequest low.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= air_pkg::AIR_IDLE;
    end else begin
      unique case (state)
        air_pkg::AIR_IDLE: begin
          if (take) begin
            state <= air_pkg::AIR_ACK;
          end
        end
        air_pkg::AIR_ACK: begin
          state <= air_pkg::AIR_IDLE;
        end
      endcase
    end
  end

  // Waitrequest idles high so that a request is never taken before decode.
  // The price is one wait state on every access, two cycles in all.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !take;
    end
  end

  // Read data and answer are captured when the request is taken and stand
  // until the next request is taken.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata <= air_pkg::AIR_RDATA_RESET;
      response <= air_pkg::AIR_RESP_OKAY;
    end else if (take) begin
      readdata <= next_readdata;
      response <= next_response;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Answer comes exactly one cycle after the request is taken.
  bus_ack_once_a: assert property (take |=> !waitrequest ##1 waitrequest)
    else $error("answer not given for exactly one cycle");

  // Upper lanes are always zero in an answer.
  upper_lanes_a: assert property (!waitrequest |-> readdata[31:8] == 24'h000000)
    else $error("upper read data bits not zero");

  // Unmapped index gives zero data and an error.
  unmapped_err_a: assert property (take && !mapped |=>
                                   response == air_pkg::AIR_RESP_SLVERR && readdata == air_pkg::AIR_RDATA_RESET)
    else $error("unmapped access not refused");

  // Values right after reset release.
  reset_value_a: assert property ($fell(rst) |->
                                  ch_low[0] == air_pkg::AIR_LO_RESET &&
                                  ch_high[1] == air_pkg::AIR_HI_RESET)
    else $error("wrong value after reset");

  // The read checks compare the captured answer with the byte as it stood at
  // the taking edge; that is the byte the lock protects, so a conversion in the
  // answer cycle must not leak into the data the host receives.

  // Input 5 high byte is served at its own index.
  in5_high_read_a: assert property (take && read && idx == air_pkg::AIR_IDX_IN5_HI |=>
                                    readdata[7:0] == $past(ch_high[0]))
    else $error("input 5 high byte read wrong");

  // Input 5 low byte is served at its own index.
  in5_low_read_a: assert property (take && read && idx == air_pkg::AIR_IDX_IN5_LO |=>
                                   readdata[7:0] == $past(ch_low[0]))
    else $error("input 5 low byte read wrong");

  // Input 6 high byte is served at its own index.
  in6_high_read_a: assert property (take && read && idx == air_pkg::AIR_IDX_IN6_HI |=>
                                    readdata[7:0] == $past(ch_high[1]))
    else $error("input 6 high byte read wrong");

  // Input 6 low byte is served at the next index.
  in6_low_read_a: assert property (take && read && idx == air_pkg::AIR_IDX_IN6_LO |=>
                                   readdata[7:0] == $past(ch_low[1]))
    else $error("input 6 low byte read wrong");

  // Input 7 high byte is served at its own index.
  in7_high_read_a: assert property (take && read && idx == air_pkg::AIR_IDX_IN7_HI |=>
                                    readdata[7:0] == $past(ch_high[2]))
    else $error("input 7 high byte read wrong");

  // Input 7 low byte is served at the next index.
  in7_low_read_a: assert property (take && read && idx == air_pkg::AIR_IDX_IN7_LO |=>
                                   readdata[7:0] == $past(ch_low[2]))
    else $error("input 7 low byte read wrong");

  // Input 8 high byte is served at its own index.
  in8_high_read_a: assert property (take && read && idx == air_pkg::AIR_IDX_IN8_HI |=>
                                    readdata[7:0] == $past(ch_high[3]))
    else $error("input 8 high byte read wrong");

  // Input 8 low byte is served right above its high byte.
  in8_low_read_a: assert property (take && read && idx == air_pkg::AIR_IDX_IN8_LO |=>
                                   readdata[7:0] == $past(ch_low[3]))
    else $error("input 8 low byte read wrong");

  // Input 5 high read locks and holds the low byte.
  in5_lock_a: assert property (take && read && idx == air_pkg::AIR_IDX_IN5_HI |=>
                               lock_status[0] && $stable(ch_low[0]))
    else $error("input 5 high read did not lock");

  // Input 6 high read locks and holds the low byte.
  in6_lock_a: assert property (take && read && idx == air_pkg::AIR_IDX_IN6_HI |=>
                               lock_status[1] && $stable(ch_low[1]))
    else $error("input 6 high read did not lock");

  // Input 7 high read locks and holds the low byte.
  in7_lock_a: assert property (take && read && idx == air_pkg::AIR_IDX_IN7_HI |=>
                               lock_status[2] && $stable(ch_low[2]))
    else $error("input 7 high read did not lock");

  // Input 8 high read locks the input 8 low byte.
  in8_lock_a: assert property (take && read && idx == air_pkg::AIR_IDX_IN8_HI |=>
                               lock_status[3] ##1 $stable(ch_low[3]))
    else $error("input 8 high read did not lock");

  // Input 5 high read locks, and a later low read then unlocks it.
  in5_cycle_a: assert property (rd_hi[0] ##[2:20] rd_lo[0] |=> !lock_status[0])
    else $error("input 5 lock cycle wrong");

  // Input 6 lock is dropped by its own low read.
  in6_unlock_a: assert property (lock_status[1] && rd_lo[1] |=> !lock_status[1])
    else $error("input 6 lock not dropped");

  // Input 7 lock is dropped by its own low read.
  in7_unlock_a: assert property (lock_status[2] && rd_lo[2] |=> !lock_status[2])
    else $error("input 7 lock not dropped");

  // Input 8 lock is dropped by its own low read.
  in8_unlock_a: assert property (lock_status[3] && rd_lo[3] |=> !lock_status[3])
    else $error("input 8 lock not dropped");

  // Lock stays set until a low read of the same input.
  lock_hold_a: assert property (lock_status[1] && !rd_lo[1] |=> lock_status[1])
    else $error("lock dropped without a low read");

  // A lock is raised only by a high read of the same input.
  lock_set_only_a: assert property (!lock_status[1] && !rd_hi[1] |=> !lock_status[1])
    else $error("lock raised without a high read");

  // The high byte is never frozen.
  high_follows_a: assert property (result[1].valid |=> ch_high[1] == $past(result[1].high))
    else $error("high byte missed a conversion");

  // The low byte follows a conversion when unlocked or at the unlocking read.
  low_follows_a: assert property (result[1].valid && (!lock_status[1] || rd_lo[1]) && !rd_hi[1] |=>
                                  ch_low[1] == $past(result[1].low))
    else $error("low byte missed a conversion");

  // A write changes no lock.
  write_ignore_a: assert property (take && write |=> lock_status == $past(lock_status))
    else $error("write disturbed the bank");

  // A mapped index answers without error, also for an ignored write.
  mapped_okay_a: assert property (take && mapped |=> response == air_pkg::AIR_RESP_OKAY)
    else $error("mapped access refused");

  // An unmapped access leaves every lock as it was.
  unmapped_quiet_a: assert property (take && !mapped |=> lock_status == $past(lock_status))
    else $error("unmapped access disturbed a lock");

  // The answer stands until the next request is taken.
  answer_stands_a: assert property (!take |=> $stable(readdata) && $stable(response))
    else $error("answer changed without a request");

  // Main scenarios.
  pair_read_c: cover property (rd_hi[1] ##[1:20] rd_lo[1]);
  conv_locked_c: cover property (lock_status[2] && result[2].valid);
  unmapped_c: cover property (take && !mapped);
  write_c: cover property (take && write && mapped);
  unlock_c: cover property (lock_status[0] && rd_lo[0]);

endmodule

// ==== logic/air_channel.sv ====
// One input's high and low result bytes with the read coherency lock.
`timescale 1ns/1ps
module air_channel (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire air_pkg::air_result_s result,
  input  wire logic                 rd_hi,
  input  wire logic                 rd_lo,
  output logic [7:0]                high,
  output logic [7:0]                low,
  output logic                      locked
);

  // ==========================================================================
  // Lock control
  // ==========================================================================
  logic       freeze;
  logic       release_lock;
  logic [7:0] pend;
  logic       pend_valid;

  // The lock acts in the very cycle of the high read, so a conversion landing
  // on that edge cannot tear the pair that the host is about to assemble.
  assign freeze       = locked | rd_hi;
  assign release_lock = locked & rd_lo & ~rd_hi;

  // Lock is set by a high read and dropped once the low byte is read too.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      locked <= 1'b0;
    end else if (rd_hi) begin
      locked <= 1'b1;
    end else if (rd_lo) begin
      locked <= 1'b0;
    end
  end

  // ==========================================================================
  // Result bytes
  // ==========================================================================
  // The high byte always follows the converter.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      high <= air_pkg::AIR_HI_RESET;
    end else if (result.valid) begin
      high <= result.high;
    end
  end

  // The low byte is frozen while locked; a conversion held back meanwhile is
  // applied at release so that the pair is coherent again at once.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low <= air_pkg::AIR_LO_RESET;
    end else if (result.valid && (!freeze || release_lock)) begin
      low <= result.low;
    end else if (release_lock && pend_valid) begin
      low <= pend;
    end
  end

  // Holding register for the newest low byte seen during the lock.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend       <= air_pkg::AIR_LO_RESET;
      pend_valid <= 1'b0;
    end else if (result.valid && freeze && !release_lock) begin
      pend       <= result.low;
      pend_valid <= 1'b1;
    end else if (release_lock) begin
      pend_valid <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  low_frozen_a: assert property (freeze && !release_lock |=> $stable(low))
    else $error("low byte changed while locked");
  lock_release_a: assert property (release_lock |=> !locked)
    else $error("lock not dropped after low read");
  pend_apply_a: assert property (release_lock && pend_valid && !result.valid |=> low == $past(pend))
    else $error("held conversion not applied at release");

endmodule
